// ===== pkg/dac_link_pkg.sv
// shared constants for the three-wire converter write link
package dac_link_pkg;
   // -----------------------------------------------------------------
   // word layout
   // -----------------------------------------------------------------
   localparam int WORD_BITS = 16;
   localparam int CODE_BITS = 12;
   localparam int MODE_HI_POS = 13;
   localparam int MODE_LO_POS = 12;
   localparam int CODE_MSB_POS = 11;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] LAST_BIT_CNT = 5'h10;
   // -----------------------------------------------------------------
   // reset values
   // -----------------------------------------------------------------
   localparam logic [11:0] CODE_RST = 12'h000;
   localparam logic [15:0] SHIFT_RST = 16'h0000;
   // -----------------------------------------------------------------
   // operating modes
   // -----------------------------------------------------------------
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_PD_5K = 2'h1;
   localparam logic [1:0] MODE_PD_100K = 2'h2;
   localparam logic [1:0] MODE_PD_HIZ = 2'h3;
   // -----------------------------------------------------------------
   // host timing: link clock = 2*HALF_CYCLES system clocks
   // -----------------------------------------------------------------
   localparam int SYS_PERIOD_PS = 4000;
   localparam int SCLK_HALF_NS = 25;
   localparam int SCLK_HALF_CYCLES =
      (SCLK_HALF_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
   localparam int SYNC_HIGH_NS = 37;
   localparam int SYNC_HIGH_CYCLES =
      (SYNC_HIGH_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
   localparam int TMR_W = 8;
endpackage

// ===== pkg/dac_link_if.sv
// three-wire write link between host and converter front end
`timescale 1ns/1ps
interface dac_link_if;
   logic sync_n;
   logic sclk;
   logic din;
   modport host (output sync_n, output sclk, output din);
   modport device (input sync_n, input sclk, input din);
endinterface

// ===== src/dac_write_device.sv
// converter front end: serial word capture, code and mode registers
`timescale 1ns/1ps
module dac_write_device
   import dac_link_pkg::*;
#(
   parameter int WIDTH = WORD_BITS
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   dac_link_if.device link,
   output logic [CODE_BITS-1:0] o_code,
   output logic [1:0] o_mode,
   output logic o_analog_en,
   output logic o_pull_5k,
   output logic o_pull_100k,
   output logic o_out_hiz,
   output logic o_loaded
);
   // -----------------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------------
   logic [1:0] sync_n_r;
   logic [1:0] sclk_r;
   logic [1:0] din_r;
   logic sync_n_d_r;
   logic sclk_d_r;
   logic [WIDTH-1:0] shift_r;
   logic [CNT_W-1:0] cnt_r;
   logic [CODE_BITS-1:0] code_r;
   logic [1:0] mode_r;
   logic loaded_r;
   logic frame_start;
   logic sclk_fall;
   logic word_done;
   logic [3:0] mode_flags;

   // one-hot analog controls: normal, 5k pull, 100k pull, hi-z
   function automatic logic [3:0] mode_onehot(input logic [1:0] m);
      case (m)
         MODE_NORMAL: mode_onehot = 4'h8;
         MODE_PD_5K: mode_onehot = 4'h4;
         MODE_PD_100K: mode_onehot = 4'h2;
         MODE_PD_HIZ: mode_onehot = 4'h1;
         default: mode_onehot = 4'h8;
      endcase
   endfunction

   // all four controls come from one decode so they can never overlap
   assign mode_flags = mode_onehot(mode_r);

   // two flops per pin; logic reads the second stage, plus a delayed copy of select and clock for edges
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         sync_n_r <= 2'h3;
         sclk_r <= 2'h0;
         din_r <= 2'h0;
         sync_n_d_r <= 1'h1;
         sclk_d_r <= 1'h0;
      end else begin
         sync_n_r <= {sync_n_r[0], link.sync_n};
         sclk_r <= {sclk_r[0], link.sclk};
         din_r <= {din_r[0], link.din};
         sync_n_d_r <= sync_n_r[1];
         sclk_d_r <= sclk_r[1];
      end
   end

   assign frame_start = sync_n_d_r && !sync_n_r[1];
   assign sclk_fall = sclk_d_r && !sclk_r[1];
   // a word counts as done only while the frame is still open
   assign word_done = !sync_n_r[1] && sclk_fall &&
      (cnt_r == LAST_BIT_CNT - 5'h01);

   // -----------------------------------------------------------------
   // input shift register and bit counter
   // -----------------------------------------------------------------
   // falls after the sixteenth are ignored until select is re-armed,
   // so a host that keeps select low cannot corrupt the loaded word
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         shift_r <= SHIFT_RST;
         cnt_r <= '0;
      end else if (sync_n_r[1] || frame_start) begin
         shift_r <= SHIFT_RST;
         cnt_r <= '0;
      end else if (sclk_fall && cnt_r != LAST_BIT_CNT) begin
         shift_r <= {shift_r[WIDTH-2:0], din_r[1]};
         cnt_r <= cnt_r + 5'h01;
      end
   end

   // -----------------------------------------------------------------
   // code and mode registers
   // -----------------------------------------------------------------
   // bits above the mode pair are don't-care and never stored
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         code_r <= CODE_RST;
         mode_r <= MODE_NORMAL;
         loaded_r <= 1'h0;
      end else if (word_done) begin
         code_r <= {shift_r[CODE_BITS-2:0], din_r[1]};
         mode_r <= shift_r[MODE_HI_POS-1:MODE_LO_POS-1];
         loaded_r <= 1'h1;
      end
   end // otherwise held

   // -----------------------------------------------------------------
   // outputs: analog enables decoded from mode
   // -----------------------------------------------------------------
   // until the first write the code is zero, so output sits at 0 V
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         o_code <= CODE_RST;
         o_mode <= MODE_NORMAL;
         o_analog_en <= 1'h1;
         o_pull_5k <= 1'h0;
         o_pull_100k <= 1'h0;
         o_out_hiz <= 1'h0;
         o_loaded <= 1'h0;
      end else begin
         o_code <= code_r;
         o_mode <= mode_r;
         o_analog_en <= mode_flags[3];
         o_pull_5k <= mode_flags[2];
         o_pull_100k <= mode_flags[1];
         o_out_hiz <= mode_flags[0];
         o_loaded <= loaded_r;
      end
   end
endmodule

// ===== src/dac_write_host.sv
// host end: sends one 16-bit word per request over the three-wire link
`timescale 1ns/1ps
module dac_write_host
   import dac_link_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   dac_link_if.host link,
   input wire logic i_valid,
   input wire logic [1:0] i_mode,
   input wire logic [CODE_BITS-1:0] i_code,
   output logic o_ready
);
   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_HIGH = 4'h2,
      ST_LOW = 4'h4,
      ST_GAP = 4'h8
   } host_st_e;
   localparam logic [TMR_W-1:0] HALF_T = TMR_W'(SCLK_HALF_CYCLES - 1);
   localparam logic [TMR_W-1:0] GAP_T = TMR_W'(SYNC_HIGH_CYCLES - 1);

   host_st_e st_r;
   logic [TMR_W-1:0] tmr_r;
   logic [CNT_W-1:0] bit_r;
   logic [WORD_BITS-1:0] word_r;
   logic sync_n_r;
   logic sclk_r;
   logic din_r;
   logic tmr_done;

   assign tmr_done = (tmr_r == '0);
   assign o_ready = (st_r == ST_IDLE);
   assign link.sync_n = sync_n_r;
   assign link.sclk = sclk_r;
   assign link.din = din_r;

   // -----------------------------------------------------------------
   // sequencer: clock high, clock low with fall, gap with select high
   // -----------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         st_r <= ST_IDLE;
         tmr_r <= '0;
         bit_r <= '0;
         word_r <= SHIFT_RST;
         sync_n_r <= 1'h0; // idle low
         sclk_r <= 1'h0;
         din_r <= 1'h0;
      end else begin
         case (st_r)
            ST_IDLE: begin
               if (i_valid) begin
                  word_r <= {2'h0, i_mode, i_code};
                  // select already low, first bit set up before first fall
                  sync_n_r <= 1'h0;
                  sclk_r <= 1'h1;
                  din_r <= 1'h0; // leading don't-care bit first
                  bit_r <= '0;
                  tmr_r <= HALF_T;
                  st_r <= ST_HIGH;
               end
            end
            ST_HIGH: begin
               if (tmr_done) begin
                  sclk_r <= 1'h0; // falling edge samples din
                  tmr_r <= HALF_T;
                  st_r <= ST_LOW;
               end else begin
                  tmr_r <= tmr_r - 8'h01;
               end
            end
            ST_LOW: begin
               if (!tmr_done) begin
                  tmr_r <= tmr_r - 8'h01;
               end else if (bit_r == LAST_BIT_CNT - 5'h01) begin
                  sync_n_r <= 1'h1; // close frame for min high
                  din_r <= 1'h0;
                  tmr_r <= GAP_T;
                  st_r <= ST_GAP;
               end else begin
                  bit_r <= bit_r + 5'h01;
                  word_r <= {word_r[WORD_BITS-2:0], 1'h0};
                  din_r <= word_r[WORD_BITS-2];
                  sclk_r <= 1'h1;
                  tmr_r <= HALF_T;
                  st_r <= ST_HIGH;
               end
            end
            ST_GAP: begin
               if (tmr_done) begin
                  sync_n_r <= 1'h0; // park low, clock stopped
                  st_r <= ST_IDLE;
               end else begin
                  tmr_r <= tmr_r - 8'h01;
               end
            end
            default: begin
               st_r <= ST_IDLE;
            end
         endcase
      end
   end
endmodule

// ===== tb/dac_link_props.sv
// assertion checker for the write link and converter outputs
`timescale 1ns/1ps
module dac_link_props
   import dac_link_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_sync_n,
   input wire logic i_sclk,
   input wire logic i_din,
   input wire logic [CODE_BITS-1:0] i_code,
   input wire logic [1:0] i_mode,
   input wire logic i_analog_en,
   input wire logic i_pull_5k,
   input wire logic i_pull_100k,
   input wire logic i_out_hiz,
   input wire logic i_loaded
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_n);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   // exactly one analog control follows the loaded mode
   property p_decode;
      {i_analog_en, i_pull_5k, i_pull_100k, i_out_hiz} == (4'h8 >> i_mode);
   endproperty
   a_decode: assert property (p_decode)
      else $error("mode decode mismatch");
   // leaving reset shows a zero code and nothing loaded
   property p_reset;
      $rose(i_rst_n) |-> i_code == CODE_RST && !i_loaded;
   endproperty
   a_reset: assert property (p_reset)
      else $error("reset state wrong");
   // no update can still be in flight once select has stayed high
   property p_hold;
      i_sync_n [*8] |=> $stable(i_code) && $stable(i_mode);
   endproperty
   a_hold: assert property (p_hold)
      else $error("outputs moved without a word");
   // a taken word stays taken
   property p_sticky;
      i_loaded |=> i_loaded;
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("loaded flag dropped");
   // select stays high long enough between words
   property p_gap;
      $rose(i_sync_n) |=> i_sync_n [*8];
   endproperty
   a_gap: assert property (p_gap)
      else $error("select high time too short");
   // data parked low whenever select is high
   property p_park;
      i_sync_n |-> !i_din;
   endproperty
   a_park: assert property (p_park)
      else $error("data not parked low");
   // link clock stands low outside frames
   property p_sclk_idle;
      i_sync_n |-> !i_sclk;
   endproperty
   a_sclk_idle: assert property (p_sclk_idle)
      else $error("link clock runs outside frame");
   // half periods long enough for the sampler
   property p_half;
      $changed(i_sclk) |=> $stable(i_sclk) [*2];
   endproperty
   a_half: assert property (p_half)
      else $error("link clock half period too short");
endmodule

// ===== tb/serial_dac_write_interface_tb.sv
// bench: host and converter ends joined, plus a converter driven raw
`timescale 1ns/1ps
module serial_dac_write_interface_tb;
   import dac_link_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic valid = 1'b0;
   logic [1:0] hmode = 2'h0;
   logic [11:0] hcode = 12'h000;
   logic ready, ld1, ld2;
   logic [1:0] mode1, mode2;
   wire logic [3:0] fl1, fl2;
   logic [11:0] code1, code2;
   logic [15:0] wire_word = 16'h0000;
   int bad_count = 0;
   int samples_checked = 0;
   wire logic [18:0] st1 = {ld1, fl1, mode1, code1};
   wire logic [18:0] st2 = {ld2, fl2, mode2, code2};
   dac_link_if link();
   dac_link_if link2();
   dac_write_host dac_write_host_i(.i_sys_clk(clk), .i_rst_n(rst_n),
      .link(link), .i_valid(valid), .i_mode(hmode), .i_code(hcode),
      .o_ready(ready));
   dac_write_device dac_write_device_i(.i_sys_clk(clk), .i_rst_n(rst_n),
      .link(link), .o_code(code1), .o_mode(mode1), .o_analog_en(fl1[3]),
      .o_pull_5k(fl1[2]), .o_pull_100k(fl1[1]), .o_out_hiz(fl1[0]),
      .o_loaded(ld1));
   // second end faces the bench so broken frames can be sent
   dac_write_device dac_write_device_aux_i(.i_sys_clk(clk),
      .i_rst_n(rst_n), .link(link2), .o_code(code2), .o_mode(mode2),
      .o_analog_en(fl2[3]), .o_pull_5k(fl2[2]), .o_pull_100k(fl2[1]),
      .o_out_hiz(fl2[0]), .o_loaded(ld2));
   dac_link_props dac_link_props_i(.i_sys_clk(clk), .i_rst_n(rst_n),
      .i_sync_n(link.sync_n), .i_sclk(link.sclk), .i_din(link.din),
      .i_code(code1), .i_mode(mode1), .i_analog_en(fl1[3]),
      .i_pull_5k(fl1[2]), .i_pull_100k(fl1[1]), .i_out_hiz(fl1[0]),
      .i_loaded(ld1));
   initial begin
      forever #2 clk = ~clk;
   end
   // independent view of the wire: what the link really carried
   always @(negedge link.sclk) begin
      if (!link.sync_n) wire_word <= {wire_word[14:0], link.din};
   end
   task automatic check(input logic [19:0] seen, input logic [19:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic chk_dev(input logic [18:0] seen, input logic l,
      input logic [1:0] m, input logic [11:0] c);
      check(20'(seen), 20'({l, 4'h8 >> m, m, c}));
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // one word through the host; called only while the host is idle
   task automatic host_write(input logic [1:0] m, input logic [11:0] c);
      int w;
      @(negedge clk);
      valid = 1'b1;
      hmode = m;
      hcode = c;
      @(negedge clk);
      valid = 1'b0;
      for (w = 0; w < 400 && ready !== 1'b1; w++) @(negedge clk);
      check(20'(ready), 20'h00001);
      check(20'(wire_word), 20'({2'h0, m, c}));
      chk_dev(st1, 1'b1, m, c);
   endtask
   // raw frame of n bits, 125 ns clock kept off the system edges
   task automatic raw_frame(input logic [17:0] bits, input int n);
      int k;
      @(negedge clk);
      #0.7 link2.sync_n = 1'b0;
      for (k = 0; k < n; k++) begin
         #62.5 link2.sclk = 1'b1;
         link2.din = bits[17-k];
         #62.5 link2.sclk = 1'b0;
      end
      #62.5 link2.sync_n = 1'b1;
      link2.din = 1'b0;
      #62.5 link2.sync_n = 1'b0;
      repeat (8) @(negedge clk);
   endtask
   task automatic t_modes();
      logic [11:0] tbl [5] = '{12'hFFF, 12'h000, 12'h800, 12'h5A3, 12'h7FF};
      int i;
      for (i = 0; i < 5; i++) host_write(2'(i % 4), tbl[i]);
      repeat (300) @(negedge clk);
      chk_dev(st1, 1'b1, 2'h0, 12'h7FF);
   endtask
   task automatic t_faults();
      raw_frame({2'h3, 2'h1, 12'h3C7, 2'h0}, 16);
      chk_dev(st2, 1'b1, 2'h1, 12'h3C7);
      raw_frame({2'h0, 2'h2, 12'h0F0, 2'h0}, 15);
      chk_dev(st2, 1'b1, 2'h1, 12'h3C7);
      raw_frame({2'h0, 2'h0, 12'hABC, 2'h3}, 18);
      chk_dev(st2, 1'b1, 2'h0, 12'hABC);
   endtask
   initial begin
      link2.sync_n = 1'b0;
      link2.sclk = 1'b0;
      link2.din = 1'b0;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      repeat (5) @(negedge clk);
      chk_dev(st1, 1'b0, 2'h0, 12'h000);
      chk_dev(st2, 1'b0, 2'h0, 12'h000);
      t_modes();
      t_faults();
      report_and_stop();
   end
   // whole run is near 13 us; a hang ends well past that
   initial begin
      #100000;
      bad_count++;
      report_and_stop();
   end
endmodule
